/* hdl/rcf_top.v */
// Operation
// [RQ1] config field 01: soft enable bit turns brown-out detection on or off.
// [RQ2] other config values: soft enable stays read/write but is ignored.
// [RQ3] software keeps the reserved bit below the soft enable at zero.
// [RQ4] lowest brownout_control bit reads whether the detector is active.
// [RQ5] reset processing changes only the flag matching the reset cause.
// [RQ6] hardware never restores a flag; software writes it back inactive.
// [RQ7] software may set flags active; stored, read back, no reset.
// [RQ8] stack overflow sets bit 7; it holds until firmware clears it.
// [RQ9] stack underflow sets bit 6; it holds until firmware clears it.
// [RQ10] watchdog reset clears bit 4; one means none or firmware wrote one.
// [RQ11] reset-pin reset clears bit 3; otherwise reads one or firmware wrote.
// [RQ12] reset instruction clears bit 2; one means none or firmware wrote.
// [RQ13] power-on clears bit 1; software sets it to spot later power-ons.
// [RQ14] brown-out reset clears bit 0; software sets it again afterwards.
// [RQ15] brown-out condition is main detector OR low-power detector.
// [RQ16] hardware cause update wins over a same-cycle software write.
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "rcf_defs.vh"

module rcf_top (
  // clock and reset
  input  wire                   mclk_in,
  input  wire                   rst_b_in,
  // register port
  input  wire [`RCF_ADDR_W-1:0] addr_in,
  input  wire [`RCF_DATA_W-1:0] wr_data_in,
  input  wire                   wr_en_in,
  input  wire                   rd_en_in,
  output reg  [`RCF_DATA_W-1:0] rd_data_out,
  // configuration fuses
  input  wire [1:0]             brownout_config_field_in,
  input  wire                   low_power_brownout_en_in,
  input  wire                   pin_reset_en_in,
  input  wire                   low_voltage_prog_in,
  // power state and analog detectors
  input  wire                   sleep_in,
  input  wire                   brownout_analog_active_in,
  input  wire                   main_brownout_detector_in,
  input  wire                   low_power_brownout_detector_in,
  // reset causes, high while the cause is being processed
  input  wire                   power_on_event_in,
  input  wire                   watchdog_timeout_in,
  input  wire                   pin_reset_in,
  input  wire                   reset_instruction_in,
  input  wire                   stack_overflow_in,
  input  wire                   stack_underflow_in,
  // detector control and status
  output wire                   brownout_detect_en_out,
  output wire                   brownout_circuit_ready_out,
  output reg                    brownout_condition_out
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  wire       soft_brownout_enable;
  wire       reserved_bit;
  wire [7:0] power_control_flags;
  wire       sel_brownout_ctl;
  wire       sel_power_flags;
  wire       sel_cause_live;
  wire       wr_brownout_ctl;
  wire       wr_power_flags;
  wire       pin_reset_enabled;
  wire       main_brownout_qualified;
  wire       low_power_qualified;
  wire       brownout_condition;
  wire [7:0] hw_event;
  wire [7:0] cause_live;
  wire [7:0] brownout_ctl_view;
  reg  [7:0] next_rd_data;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // each register owns one address; anything else is unmapped
  assign sel_brownout_ctl = (addr_in == `RCF_OFS_BROWNOUT_CTL);
  assign sel_power_flags  = (addr_in == `RCF_OFS_POWER_FLAGS);
  assign sel_cause_live   = (addr_in == `RCF_OFS_CAUSE_LIVE);

  // writes to unmapped or read-only addresses are dropped silently
  assign wr_brownout_ctl  = wr_en_in & sel_brownout_ctl;
  assign wr_power_flags   = wr_en_in & sel_power_flags;

  // ---------------------------------------------------------------
  // brown-out condition
  // ---------------------------------------------------------------
  // the main detector only counts while it has been enabled; the
  // low-power detector has its own fuse and runs in every mode
  assign main_brownout_qualified = main_brownout_detector_in & brownout_detect_en_out;
  assign low_power_qualified     = low_power_brownout_detector_in & low_power_brownout_en_in;
  assign brownout_condition      = main_brownout_qualified | low_power_qualified; // [RQ15]

  // registered copy for the reset controller outside
  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      brownout_condition_out <= 1'b0;
    end else begin
      brownout_condition_out <= brownout_condition;
    end
  end

  // ---------------------------------------------------------------
  // reset cause qualification
  // ---------------------------------------------------------------
  // the pin only resets the part when the pin function is enabled,
  // either by its own fuse or by low-voltage programming
  assign pin_reset_enabled = pin_reset_in & (pin_reset_en_in | low_voltage_prog_in);

  // one event line per flag; each touches only its own bit
  assign hw_event[`RCF_PF_STACK_OVF]  = stack_overflow_in;          // [RQ8] [RQ5]
  assign hw_event[`RCF_PF_STACK_UNF]  = stack_underflow_in;         // [RQ9] [RQ5]
  assign hw_event[5]                  = 1'b0;
  assign hw_event[`RCF_PF_WATCHDOG_N] = watchdog_timeout_in;        // [RQ10] [RQ5]
  assign hw_event[`RCF_PF_PIN_N]      = pin_reset_enabled;          // [RQ11] [RQ5]
  assign hw_event[`RCF_PF_INSTR_N]    = reset_instruction_in;       // [RQ12] [RQ5]
  assign hw_event[`RCF_PF_POWER_ON_N] = power_on_event_in;          // [RQ13] [RQ5]
  assign hw_event[`RCF_PF_BROWNOUT_N] = brownout_condition;         // [RQ14] [RQ5]

  // ---------------------------------------------------------------
  // power_control_flags
  // ---------------------------------------------------------------
  // set-by-hardware bits go to one, cleared-by-hardware bits to zero;
  // no path ever returns a flag to its inactive value on its own
  rcf_flag_bank u_flags (
    .mclk_in     (mclk_in),
    .rst_b_in    (rst_b_in),
    .hw_event_in (hw_event),
    .sw_wr_in    (wr_power_flags),
    .sw_data_in  (wr_data_in),
    .flags_out   (power_control_flags)
  );

  // ---------------------------------------------------------------
  // brownout_control
  // ---------------------------------------------------------------
  rcf_brownout_ctl u_brownout (
    .mclk_in                    (mclk_in),
    .rst_b_in                   (rst_b_in),
    .sw_wr_in                   (wr_brownout_ctl),
    .sw_data_in                 (wr_data_in),
    .brownout_reset_in          (brownout_condition),
    .brownout_config_field_in   (brownout_config_field_in),
    .sleep_in                   (sleep_in),
    .analog_active_in           (brownout_analog_active_in),
    .soft_brownout_enable_out   (soft_brownout_enable),
    .reserved_out               (reserved_bit),
    .detect_en_out              (brownout_detect_en_out),
    .brownout_circuit_ready_out (brownout_circuit_ready_out)
  );

  // ---------------------------------------------------------------
  // read views
  // ---------------------------------------------------------------
  // bits 5..1 of brownout_control are unimplemented and read zero
  assign brownout_ctl_view = {soft_brownout_enable,
                              reserved_bit,
                              5'h00,
                              brownout_circuit_ready_out};  // [RQ4]

  // live cause inputs, handy for firmware that polls without a reset
  assign cause_live = {stack_overflow_in,
                       stack_underflow_in,
                       1'b0,
                       watchdog_timeout_in,
                       pin_reset_enabled,
                       reset_instruction_in,
                       power_on_event_in,
                       brownout_condition};

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  // flags read back exactly as stored, including values that
  // software forced active for testing
  always @* begin
    next_rd_data = 8'h00;
    if (!rd_en_in) begin
      next_rd_data = 8'h00;
    end else if (sel_brownout_ctl) begin
      next_rd_data = brownout_ctl_view;
    end else if (sel_power_flags) begin
      next_rd_data = power_control_flags;                  // [RQ7]
    end else if (sel_cause_live) begin
      next_rd_data = cause_live;
    end else begin
      next_rd_data = 8'h00;
    end
  end

  // read data stand for the one cycle after the strobe, zero otherwise
  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_data_out <= 8'h00;
    end else begin
      rd_data_out <= next_rd_data;
    end
  end

endmodule

/* hdl/rcf_defs.vh */
`ifndef RCF_DEFS_VH
`define RCF_DEFS_VH

// ---------------------------------------------------------------
// register map (byte-wide registers on the plain register port)
// ---------------------------------------------------------------
`define RCF_ADDR_W            4
`define RCF_DATA_W            8
`define RCF_OFS_BROWNOUT_CTL  4'h0
`define RCF_OFS_POWER_FLAGS   4'h1
`define RCF_OFS_CAUSE_LIVE    4'h2

// ---------------------------------------------------------------
// brownout_control fields and reset values
// ---------------------------------------------------------------
`define RCF_BC_SOFT_EN        7
`define RCF_BC_RSVD           6
`define RCF_BC_READY          0
`define RCF_BC_RST_SOFT_EN    1'b1
`define RCF_BC_RST_RSVD       1'b0

// ---------------------------------------------------------------
// brownout configuration field encodings
// ---------------------------------------------------------------
`define RCF_CFG_OFF           2'h0
`define RCF_CFG_SOFT          2'h1
`define RCF_CFG_AWAKE         2'h2
`define RCF_CFG_ALWAYS        2'h3

// ---------------------------------------------------------------
// power_control_flags fields, implemented mask, reset and hw values
// ---------------------------------------------------------------
`define RCF_PF_STACK_OVF      7
`define RCF_PF_STACK_UNF      6
`define RCF_PF_WATCHDOG_N     4
`define RCF_PF_PIN_N          3
`define RCF_PF_INSTR_N        2
`define RCF_PF_POWER_ON_N     1
`define RCF_PF_BROWNOUT_N     0
`define RCF_PF_IMPL           8'hDF
`define RCF_PF_RST            8'h1C
`define RCF_PF_HW_VAL         8'hC0

`endif

/* hdl/rcf_flag_bank.v */
`timescale 1ns/1ps
`include "rcf_defs.vh"

module rcf_flag_bank (
  // clock and reset
  input  wire       mclk_in,
  input  wire       rst_b_in,
  // hardware cause updates, one bit per flag
  input  wire [7:0] hw_event_in,
  // software write
  input  wire       sw_wr_in,
  input  wire [7:0] sw_data_in,
  // flag contents
  output wire [7:0] flags_out
);

  localparam [7:0] IMPL   = `RCF_PF_IMPL;
  localparam [7:0] RSTVAL = `RCF_PF_RST;
  localparam [7:0] HWVAL  = `RCF_PF_HW_VAL;

  genvar i;

  // ---------------------------------------------------------------
  // one flop per implemented flag; unimplemented bits read zero
  // ---------------------------------------------------------------
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_flag
      if (IMPL[i]) begin : g_impl
        reg q;
        // hardware update beats a same-cycle software write
        always @(posedge mclk_in or negedge rst_b_in) begin
          if (!rst_b_in) begin
            q <= RSTVAL[i];
          end else if (hw_event_in[i]) begin
            q <= HWVAL[i];                                   // [RQ5] [RQ16]
          end else if (sw_wr_in) begin
            q <= sw_data_in[i];                              // [RQ6] [RQ7]
          end
        end
        assign flags_out[i] = q;
      end else begin : g_unimpl
        assign flags_out[i] = 1'b0;
      end
    end
  endgenerate

endmodule

/* hdl/rcf_brownout_ctl.v */
`timescale 1ns/1ps
`include "rcf_defs.vh"

module rcf_brownout_ctl (
  // clock and reset
  input  wire       mclk_in,
  input  wire       rst_b_in,
  // software write to brownout_control
  input  wire       sw_wr_in,
  input  wire [7:0] sw_data_in,
  // brown-out reset processing restores the soft enable
  input  wire       brownout_reset_in,
  // configuration and status from the analog side
  input  wire [1:0] brownout_config_field_in,
  input  wire       sleep_in,
  input  wire       analog_active_in,
  // register contents and detector control
  output reg        soft_brownout_enable_out,
  output reg        reserved_out,
  output reg        detect_en_out,
  output reg        brownout_circuit_ready_out
);

  reg next_detect_en;

  // ---------------------------------------------------------------
  // software bits of brownout_control
  // ---------------------------------------------------------------
  // the soft enable stays writable in every configuration
  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      soft_brownout_enable_out <= `RCF_BC_RST_SOFT_EN;
      reserved_out             <= `RCF_BC_RST_RSVD;
    end else if (brownout_reset_in) begin
      soft_brownout_enable_out <= `RCF_BC_RST_SOFT_EN;
      reserved_out             <= `RCF_BC_RST_RSVD;
    end else if (sw_wr_in) begin
      soft_brownout_enable_out <= sw_data_in[`RCF_BC_SOFT_EN];   // [RQ2]
      reserved_out             <= sw_data_in[`RCF_BC_RSVD];      // [RQ3]
    end
  end

  // ---------------------------------------------------------------
  // detector enable from the configuration field
  // ---------------------------------------------------------------
  always @* begin
    next_detect_en = 1'b0;
    case (brownout_config_field_in)
      `RCF_CFG_SOFT:   next_detect_en = soft_brownout_enable_out; // [RQ1]
      `RCF_CFG_AWAKE:  next_detect_en = ~sleep_in;                // [RQ2]
      `RCF_CFG_ALWAYS: next_detect_en = 1'b1;                     // [RQ2]
      default:         next_detect_en = 1'b0;                     // [RQ2]
    endcase
  end

  // registered so the detector sees a clean level
  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      detect_en_out              <= 1'b0;
      brownout_circuit_ready_out <= 1'b0;
    end else begin
      detect_en_out              <= next_detect_en;
      brownout_circuit_ready_out <= detect_en_out & analog_active_in; // [RQ4]
    end
  end

endmodule

/* tb/rcf_top_sva.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------
// reset-cause flag checker, sees only the top ports
// ----------------------------------------------------------
module rcf_top_sva (
  // clock and reset
  input wire       mclk_in,
  input wire       rst_b_in,
  // register port
  input wire [3:0] addr_in,
  input wire [7:0] wr_data_in,
  input wire       wr_en_in,
  input wire       rd_en_in,
  input wire [7:0] rd_data_out,
  // fuses and detectors
  input wire [1:0] brownout_config_field_in,
  input wire       low_power_brownout_en_in,
  input wire       brownout_analog_active_in,
  input wire       main_brownout_detector_in,
  input wire       low_power_brownout_detector_in,
  // reset causes
  input wire       power_on_event_in,
  input wire       watchdog_timeout_in,
  input wire       pin_reset_in,
  input wire       reset_instruction_in,
  input wire       stack_overflow_in,
  input wire       stack_underflow_in,
  // status
  input wire       brownout_detect_en_out,
  input wire       brownout_circuit_ready_out,
  input wire       brownout_condition_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  // a brown-out in the write cycle would restore the soft enable, so it is excluded
  property p_soft_ctl;
    (wr_en_in && addr_in == 4'h0 && !main_brownout_detector_in && !low_power_brownout_detector_in)
      ##1 (brownout_config_field_in == 2'h1)
      |=> brownout_detect_en_out == $past(wr_data_in[7], 2);
  endproperty
  a_soft_ctl: assert property (p_soft_ctl)
    else $error("detect enable does not follow soft enable");
  property p_cfg_off;
    brownout_config_field_in == 2'h0 |=> !brownout_detect_en_out;
  endproperty
  a_cfg_off: assert property (p_cfg_off)
    else $error("detector enabled under config 00");
  property p_cfg_on;
    brownout_config_field_in == 2'h3 |=> brownout_detect_en_out;
  endproperty
  a_cfg_on: assert property (p_cfg_on)
    else $error("detector disabled under config 11");
  property p_ready_on;
    (brownout_config_field_in == 2'h3 && brownout_analog_active_in) [*2]
      |=> brownout_circuit_ready_out;
  endproperty
  a_ready_on: assert property (p_ready_on)
    else $error("ready flag low with detector running");
  property p_ready_off;
    !brownout_analog_active_in |=> !brownout_circuit_ready_out;
  endproperty
  a_ready_off: assert property (p_ready_off)
    else $error("ready flag high with detector idle");
  property p_ovf;
    stack_overflow_in ##1 (rd_en_in && addr_in == 4'h1) |=> rd_data_out[7];
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow flag not set");
  property p_unf;
    stack_underflow_in ##1 (rd_en_in && addr_in == 4'h1) |=> rd_data_out[6];
  endproperty
  a_unf: assert property (p_unf)
    else $error("underflow flag not set");
  property p_wdt;
    watchdog_timeout_in ##1 (rd_en_in && addr_in == 4'h1) |=> !rd_data_out[4];
  endproperty
  a_wdt: assert property (p_wdt)
    else $error("watchdog flag not cleared");
  property p_por;
    power_on_event_in ##1 (rd_en_in && addr_in == 4'h1) |=> !rd_data_out[1];
  endproperty
  a_por: assert property (p_por)
    else $error("power-on flag not cleared");
  property p_ri;
    reset_instruction_in ##1 (rd_en_in && addr_in == 4'h1) |=> !rd_data_out[2];
  endproperty
  a_ri: assert property (p_ri)
    else $error("reset instruction flag not cleared");
  // the registered condition rises on the same edge that clears the flag
  property p_bor;
    brownout_condition_out && rd_en_in && addr_in == 4'h1 |=> !rd_data_out[0];
  endproperty
  a_bor: assert property (p_bor)
    else $error("brown-out flag not cleared");
  property p_sw;
    (wr_en_in && addr_in == 4'h1 && !(power_on_event_in || watchdog_timeout_in || pin_reset_in
      || reset_instruction_in || stack_overflow_in || stack_underflow_in
      || main_brownout_detector_in || low_power_brownout_detector_in))
      ##1 (rd_en_in && addr_in == 4'h1) |=> rd_data_out == ($past(wr_data_in, 2) & 8'hDF);
  endproperty
  a_sw: assert property (p_sw)
    else $error("written flags not read back");
  property p_lp;
    low_power_brownout_detector_in && low_power_brownout_en_in |=> brownout_condition_out;
  endproperty
  a_lp: assert property (p_lp)
    else $error("low-power detector ignored");
endmodule

bind rcf_top rcf_top_sva chk (.*);

/* tb/rcf_top_tb.sv */
`timescale 1ns/1ps
`include "rcf_defs.vh"
module rcf_top_tb;
  // ----------------------------------------------------------
  // stimulus, design and reference model
  // ----------------------------------------------------------
  logic       mclk_in, rst_b_in, wr_en_in, rd_en_in, sleep_in;
  logic [3:0] addr_in, a;
  logic [7:0] wr_data_in, f, d;
  logic [1:0] brownout_config_field_in;
  logic       low_power_brownout_en_in, pin_reset_en_in, low_voltage_prog_in;
  logic       brownout_analog_active_in, main_brownout_detector_in;
  logic       low_power_brownout_detector_in;
  logic [5:0] ev;
  logic [7:0] m_flags;
  logic       m_soft, m_rsv, m_det, m_rdy, m_cond;
  int         num_errors, checks_done, i;
  wire  [7:0] rd_data_out;
  wire        brownout_detect_en_out, brownout_circuit_ready_out, brownout_condition_out;
  wire        power_on_event_in = ev[0];
  wire        watchdog_timeout_in = ev[1];
  wire        pin_reset_in = ev[2];
  wire        reset_instruction_in = ev[3];
  wire        stack_overflow_in = ev[4];
  wire        stack_underflow_in = ev[5];
  wire        cnd = (main_brownout_detector_in & m_det)
                  | (low_power_brownout_detector_in & low_power_brownout_en_in);

  rcf_top dut (.*);

  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end

  // model: hardware causes are applied after the software write, so they win
  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      m_flags <= `RCF_PF_RST;
      m_soft <= 1'b1;
      m_rsv <= 1'b0;
      m_det <= 1'b0;
      m_rdy <= 1'b0;
      m_cond <= 1'b0;
    end else begin
      f = m_flags;
      if (wr_en_in && addr_in == `RCF_OFS_POWER_FLAGS) f = wr_data_in & `RCF_PF_IMPL;
      if (wr_en_in && addr_in == `RCF_OFS_BROWNOUT_CTL) {m_soft, m_rsv} <= wr_data_in[7:6];
      if (stack_overflow_in) f[7] = 1'b1;
      if (stack_underflow_in) f[6] = 1'b1;
      if (watchdog_timeout_in) f[4] = 1'b0;
      if (pin_reset_in && (pin_reset_en_in || low_voltage_prog_in)) f[3] = 1'b0;
      if (reset_instruction_in) f[2] = 1'b0;
      if (power_on_event_in) f[1] = 1'b0;
      if (cnd) begin
        f[0] = 1'b0;
        m_soft <= 1'b1;
        m_rsv <= 1'b0;
      end
      m_flags <= f;
      m_det <= (brownout_config_field_in == 2'h1) ? m_soft :
               (brownout_config_field_in == 2'h2) ? !sleep_in : (brownout_config_field_in == 2'h3);
      m_rdy <= m_det & brownout_analog_active_in;
      m_cond <= cnd;
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_stat(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // detector outputs are compared every cycle
  always @(negedge mclk_in) begin
    if (rst_b_in) begin
      check_stat(brownout_detect_en_out, m_det);
      check_stat(brownout_circuit_ready_out, m_rdy);
      check_stat(brownout_condition_out, m_cond);
    end
  end

  task wr(input logic [3:0] ad, input logic [7:0] dt);
    @(posedge mclk_in);
    addr_in <= ad;
    wr_data_in <= dt;
    wr_en_in <= 1'b1;
    @(posedge mclk_in);
    wr_en_in <= 1'b0;
  endtask

  // expectation is taken just before the sampling edge
  task rd(input logic [3:0] ad);
    logic [7:0] e;
    @(posedge mclk_in);
    addr_in <= ad;
    rd_en_in <= 1'b1;
    @(negedge mclk_in);
    e = (ad == `RCF_OFS_POWER_FLAGS) ? m_flags :
        (ad == `RCF_OFS_BROWNOUT_CTL) ? {m_soft, m_rsv, 5'h0, m_rdy} :
        (ad == `RCF_OFS_CAUSE_LIVE) ? {stack_overflow_in, stack_underflow_in, 1'b0,
          watchdog_timeout_in, pin_reset_in & (pin_reset_en_in | low_voltage_prog_in),
          reset_instruction_in, power_on_event_in, cnd} : 8'h00;
    @(posedge mclk_in);
    rd_en_in <= 1'b0;
    @(negedge mclk_in);
    check(rd_data_out, e);
    // end on a rising edge so the caller drives inputs there
    @(posedge mclk_in);
  endtask

  task cause(input logic [5:0] v);
    @(posedge mclk_in);
    ev <= v;
    @(posedge mclk_in);
    ev <= 6'h00;
  endtask

  task then_rd(input logic [3:0] ad);
    @(posedge mclk_in);
    rd(ad);
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // watchdog: the whole run needs well under 10000 cycles
  initial begin
    #200000;
    num_errors++;
    conclude;
  end

  initial begin
    {rst_b_in, wr_en_in, rd_en_in, addr_in, wr_data_in, ev, sleep_in} = '0;
    {low_power_brownout_en_in, pin_reset_en_in, low_voltage_prog_in} = 3'h0;
    {main_brownout_detector_in, low_power_brownout_detector_in} = 2'h0;
    brownout_config_field_in = 2'h1;
    brownout_analog_active_in = 1'b1;
    void'($urandom(32'hC28B));
    repeat (16) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    rd(4'h0);
    rd(4'h1);
    $display("test reset values done");
    for (i = 0; i < 16; i++) begin
      brownout_config_field_in <= i[1:0];
      sleep_in <= i[3];
      wr(4'h0, {i[2], 7'h00});
      repeat (3) @(posedge mclk_in);
      rd(4'h0);
    end
    $display("test config sweep done");
    for (i = 0; i < 8; i++) begin
      pin_reset_en_in <= (i < 6);
      low_voltage_prog_in <= (i == 7);
      wr(4'h1, 8'h1F);
      fork
        cause((i < 6) ? 6'(1 << i) : 6'h04);
        then_rd(4'h1);
      join
    end
    $display("test reset causes done");
    fork
      wr(4'h1, 8'hFF);
      then_rd(4'h1);
    join
    fork
      wr(4'h1, 8'hFF);
      cause(6'h3F);
    join
    rd(4'h1);
    rd(4'hF);
    wr(4'h9, 8'hFF);
    rd(4'h1);
    $display("test software writes done");
    for (i = 0; i < 2; i++) begin
      brownout_config_field_in <= i[0] ? 2'h0 : 2'h3;
      low_power_brownout_en_in <= i[0];
      wr(4'h1, 8'h1F);
      wr(4'h0, 8'h00);
      main_brownout_detector_in <= !i[0];
      low_power_brownout_detector_in <= i[0];
      repeat (3) @(posedge mclk_in);
      {main_brownout_detector_in, low_power_brownout_detector_in} <= 2'h0;
      rd(4'h0);
      rd(4'h1);
    end
    $display("test brown-out done");
    for (i = 0; i < 400; i++) begin
      @(posedge mclk_in);
      {brownout_config_field_in, sleep_in, brownout_analog_active_in} <= 4'($urandom);
      {low_power_brownout_en_in, pin_reset_en_in, low_voltage_prog_in} <= 3'($urandom);
      main_brownout_detector_in <= ($urandom % 16 == 0);
      low_power_brownout_detector_in <= ($urandom % 16 == 0);
      ev <= ($urandom % 4 == 0) ? 6'($urandom) : 6'h00;
      a = ($urandom % 4 == 2) ? 4'h3 : 4'($urandom % 4);
      d = 8'($urandom) & 8'hBF;
      if ($urandom % 2) wr(a, d);
      else rd(a);
    end
    $display("test random traffic done");
    conclude;
  end
endmodule
